// ---- bench/hbf_monitor.sv ----
// line and receive-side checker of the bit framer
// assumes clk_en held high, so one line bit per clock
`timescale 1ns/10ps
`default_nettype none
module hbf_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic line_bit,
   input wire logic idle_flags,
   input wire logic rx_valid,
   input wire logic rx_end,
   input wire logic rx_good
);
   logic [8:0] sh_r;
   logic [2:0] ones_r;
   logic seen_r;
   logic [3:0] nb_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // last line bits and run of ones
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_r <= 9'h1FF;
         ones_r <= 3'h0;
      end else if (clk_en) begin
         sh_r <= {sh_r[7:0], line_bit};
         ones_r <= !line_bit ? 3'h0 :
                   (ones_r == 3'h7 ? 3'h7 : ones_r + 3'h1);
      end
   end
   // inside a frame: flag seen, no abort since
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         seen_r <= 1'b0;
      end else if (clk_en && line_bit && ones_r >= 3'h6) begin
         seen_r <= 1'b0;
      end else if (clk_en && {sh_r[6:0], line_bit} == 8'h7E) begin
         seen_r <= 1'b1;
      end
   end
   // bytes since last frame end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         nb_r <= 4'h0;
      end else if (rx_end) begin
         nb_r <= 4'h0;
      end else if (rx_valid && nb_r != 4'hF) begin
         nb_r <= nb_r + 4'h1;
      end
   end
   AST_END_FLAG: assert property (rx_end |->
      (sh_r[7:0] == 8'h7E || sh_r[8:1] == 8'h7E))
      else $error("frame end without flag on line");
   AST_VALID_GAP: assert property (rx_valid |=> !rx_valid [*7])
      else $error("received bytes closer than eight bits");
   AST_VALID_IN_FRAME: assert property (rx_valid |-> seen_r)
      else $error("byte delivered outside a frame");
   AST_END_BYTES: assert property (rx_end |-> nb_r >= 4'h3)
      else $error("frame end with too few bytes");
   AST_END_GOOD: assert property (rx_end |->
      ##[0:1] rx_good)
      else $error("check sequence mismatch");
   AST_GOOD_HOLD: assert property ($changed(rx_good) |->
      rx_end || $past(rx_end))
      else $error("good flag moved outside frame end");
   AST_NO_SEVEN: assert property (clk_en && idle_flags
      && seen_r && ones_r == 3'h6 |-> !line_bit)
      else $error("seven ones in flag idle");
   AST_MARK_FLAG: assert property (clk_en && !seen_r
      && ones_r == 3'h7 && !line_bit |=> line_bit [*6] ##1 !line_bit)
      else $error("mark idle not left by a flag");
   cover property (rx_end && !idle_flags);
   cover property (rx_end && idle_flags);
   cover property (rx_valid && seen_r);
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// testbench: transmitter and receiver joined by the line
// assumes clk_en held high, bench drives at falling edge
`timescale 1ns/10ps
`default_nettype none
`include "hbf_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
   import hbf_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic idle_flags = 1'b0;
   hbf_byte_t tx_data = 8'h00;
   logic tx_last = 1'b0;
   logic tx_valid = 1'b0;
   logic tx_ready, rx_valid, rx_end, rx_good;
   hbf_byte_t rx_data;
   int n_errors = 0;
   int cmp_count = 0;
   int n_end = 0;
   int n_exp = 0;
   int n_flag = 0;
   int run = 0;
   int mx = 0;
   int n_stall = 0;
   logic [7:0] sh = 8'hFF;
   hbf_byte_t got_q[$];
   hbf_byte_t exp_q[$];
   hbf_if lnk();
   always #50 clk = ~clk;
   hbf_tx hbf_tx_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .idle_flags(idle_flags), .tx_data(tx_data), .tx_last(tx_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .link(lnk.tx_end));
   hbf_rx hbf_rx_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .link(lnk.rx_end), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_end(rx_end), .rx_good(rx_good));
   hbf_monitor hbf_monitor_i (.clk(clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .line_bit(lnk.line_bit), .idle_flags(idle_flags),
      .rx_valid(rx_valid), .rx_end(rx_end), .rx_good(rx_good));
   // collect bytes, frame ends, flags and runs on the line
   always @(negedge clk) begin
      if (rx_valid === 1'b1) got_q.push_back(rx_data);
      if (rx_end === 1'b1) n_end++;
      if ({sh[6:0], lnk.line_bit} == 8'h7E) n_flag++;
      sh <= {sh[6:0], lnk.line_bit};
      run <= (lnk.line_bit === 1'b1) ? run + 1 : 0;
      if (run > mx) mx <= run;
   end
   task send(input hbf_byte_t d, input logic l);
      tx_data = d;
      tx_last = l;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) begin
         n_stall++;
         @(negedge clk);
      end
      @(negedge clk);
   endtask
   task frame(input hbf_byte_t b[$]);
      hbf_crc_t c;
      c = `HBF_CRC_INIT;
      foreach (b[i]) begin
         send(b[i], i == b.size() - 1);
         exp_q.push_back(b[i]);
         for (int j = 0; j < 8; j++)
            c = (c >> 1) ^ ((c[0] ^ b[i][j]) ? `HBF_CRC_POLY : 16'h0000);
      end
      exp_q.push_back(~c[7:0]);
      exp_q.push_back(~c[15:8]);
      n_exp++;
   endtask
   task settle(input string nm);
      tx_valid = 1'b0;
      for (int k = 0; k < 3000 && n_end < n_exp; k++) @(negedge clk);
      @(negedge clk);
      `CHK("frames", n_exp, n_end)
      `CHK("count", exp_q.size(), got_q.size())
      foreach (exp_q[i])
         `CHK("byte", exp_q[i], got_q[i])
      `CHK("good", 1'b1, rx_good)
      exp_q.delete();
      got_q.delete();
      $display("test %s done, errors %0d", nm, n_errors);
   endtask
   task t_mark;
      repeat (16) @(negedge clk);
      `CHK("mark idle", 1'b1, lnk.line_bit)
      frame('{8'hA5});
      settle("mark");
      repeat (16) @(negedge clk);
   endtask
   task t_stuff;
      idle_flags = 1'b1;
      n_flag = 0;
      repeat (40) @(negedge clk);
      `CHK("flag idle", 1'b1, n_flag > 2)
      mx = 0;
      n_stall = 0;
      frame('{8'hFF, 8'h7E, 8'h3F, 8'hFC, 8'hF8, 8'hBE});
      settle("stuff");
      `CHK("max run", 1'b1, mx <= 6)
      `CHK("fifo full", 1'b1, n_stall > 0)
   endtask
   task t_back;
      frame('{8'h00});
      frame('{8'h01, 8'h80});
      settle("back");
   endtask
   task print_verdict;
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("ERROR watchdog exp done got hang");
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      t_mark();
      t_stuff();
      t_back();
      print_verdict();
   end
endmodule
`default_nettype wire

// ---- hdl/hbf_rx.sv ----
// receiving end: flag hunt, zero removal, fcs check, byte output
// assumes line bit valid in every cycle with clk_en high
`timescale 1ns/10ps
`default_nettype none
module hbf_rx (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   hbf_if.rx_end link,
   output hbf_pkg::hbf_byte_t rx_data,
   output logic rx_valid,
   output logic rx_end,
   output logic rx_good
);
   import hbf_pkg::*;
   logic b, is_flag, is_drop, is_abort, is_data;
   logic [2:0] ones_r, bitcnt_r;
   logic [3:0] nbytes_r;
   logic in_frame_r;
   hbf_byte_t byte_r, full;
   hbf_crc_t crc_r;

   assign b = link.line_bit;
   assign is_flag = ~b & (ones_r == `HBF_FLAG_RUN);
   assign is_drop = ~b & (ones_r == `HBF_STUFF_RUN);
   assign is_abort = b & (ones_r >= `HBF_FLAG_RUN);
   assign is_data = in_frame_r & ~is_flag & ~is_drop & ~is_abort;
   assign full = {b, byte_r[7:1]};

   // run of ones on the raw line, saturating
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ones_r <= '0;
      end else if (clk_en) begin
         ones_r <= b ? ((ones_r == 3'h7) ? ones_r : 3'(ones_r + 1'b1)) :
                   3'h0;
      end
   end

   // frame assembly; back-to-back flags and mark idle both accepted
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_frame_r <= 1'b0;
         bitcnt_r <= '0;
         nbytes_r <= '0;
         byte_r <= '0;
         crc_r <= `HBF_CRC_INIT;
      end else if (clk_en) begin
         if (is_flag) begin
            in_frame_r <= 1'b1;
            bitcnt_r <= '0;
            nbytes_r <= '0;
            crc_r <= `HBF_CRC_INIT;
         end else if (is_abort) begin
            in_frame_r <= 1'b0;
            nbytes_r <= '0;
         end else if (is_data) begin
            byte_r <= full;
            bitcnt_r <= 3'(bitcnt_r + 1'b1);
            if (bitcnt_r == 3'h7) begin
               crc_r <= hbf_crc_byte(crc_r, full);
               if (nbytes_r != 4'hF) begin
                  nbytes_r <= 4'(nbytes_r + 1'b1);
               end
            end
         end
      end
   end

   // byte and end-of-frame outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_data <= '0;
         rx_valid <= 1'b0;
         rx_end <= 1'b0;
         rx_good <= 1'b0;
      end else if (clk_en) begin
         rx_valid <= is_data & (bitcnt_r == 3'h7);
         if (is_data & (bitcnt_r == 3'h7)) begin
            rx_data <= full;
         end
         rx_end <= 1'b0;
         if (is_flag & in_frame_r & (nbytes_r != '0)) begin
            rx_end <= 1'b1;
            // residue holds only over whole bytes with the fcs included
            rx_good <= (crc_r == `HBF_CRC_GOOD) && (bitcnt_r == 3'h7) &&
                       (nbytes_r > `HBF_MIN_BYTES);
         end
      end else begin
         rx_valid <= 1'b0;
         rx_end <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/hbf_tx.sv ----
// transmitting end: byte fifo, flags, zero stuffing, fcs, idle fill
// assumes clk_en marks line bit times and sys_rst is asynchronous
`timescale 1ns/10ps
`default_nettype none
module hbf_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import hbf_pkg::*;
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r, rd_r;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   function automatic logic [AW-1:0] bump(logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   assign push = clk_en & in_valid & in_ready;
   assign pop = clk_en & out_valid & out_ready;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rd_r];

   always_comb begin
      cnt_nxt = cnt_r;
      if (push & ~pop) begin
         cnt_nxt = (AW+1)'(cnt_r + 1'b1);
      end else if (pop & ~push) begin
         cnt_nxt = (AW+1)'(cnt_r - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) begin
            wr_r <= bump(wr_r);
         end
         if (pop) begin
            rd_r <= bump(rd_r);
         end
         cnt_r <= cnt_nxt;
         in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end
endmodule

module hbf_tx #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic idle_flags,
   input wire hbf_pkg::hbf_byte_t tx_data,
   input wire logic tx_last,
   input wire logic tx_valid,
   output logic tx_ready,
   hbf_if.tx_end link
);
   import hbf_pkg::*;
   localparam hbf_byte_t FLAG = `HBF_FLAG;
   hbf_tx_state_e state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [2:0] ones_r, ones_nxt;
   hbf_byte_t sh_r, sh_nxt;
   logic last_r, last_nxt;
   hbf_crc_t crc_r, crc_nxt;
   logic bit_r, b;
   logic fill_r;
   logic f_valid, f_pop, stuff;
   logic [8:0] f_word;

   hbf_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) hbf_fifo_i (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_last, tx_data}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_word)
   );

   // a sixth bit after five ones inside the frame is a stuffed zero,
   // also ahead of the closing flag when the fcs ends in five ones
   assign stuff = ((state_r == HBF_S_DATA) || (state_r == HBF_S_FCS) ||
                   ((state_r == HBF_S_CLOSE) && (cnt_r == '0))) &&
                  (ones_r == `HBF_STUFF_RUN);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ones_nxt = ones_r;
      sh_nxt = sh_r;
      last_nxt = last_r;
      crc_nxt = crc_r;
      f_pop = 1'b0;
      b = 1'b1;
      case (state_r)
         HBF_S_IDLE: begin
            // mark idle or flag idle, frame starts on an 8-bit boundary
            b = fill_r ? FLAG[cnt_r[2:0]] : 1'b1;
            cnt_nxt = {1'b0, 3'(cnt_r[2:0] + 1'b1)};
            if ((cnt_r[2:0] == 3'h7) && f_valid) begin
               state_nxt = HBF_S_OPEN;
               cnt_nxt = '0;
            end
         end
         HBF_S_OPEN: begin
            b = FLAG[cnt_r[2:0]];
            cnt_nxt = 4'(cnt_r + 1'b1);
            if (cnt_r == `HBF_LAST_BIT) begin
               state_nxt = HBF_S_DATA;
               cnt_nxt = '0;
               sh_nxt = f_word[7:0];
               last_nxt = f_word[8];
               f_pop = 1'b1;
               crc_nxt = `HBF_CRC_INIT;
               ones_nxt = '0;
            end
         end
         HBF_S_DATA: begin
            if (stuff) begin
               b = 1'b0;
               ones_nxt = '0;
            end else begin
               b = sh_r[cnt_r[2:0]];
               crc_nxt = hbf_crc_step(crc_r, b);
               ones_nxt = b ? 3'(ones_r + 1'b1) : 3'h0;
               cnt_nxt = 4'(cnt_r + 1'b1);
               if (cnt_r == `HBF_LAST_BIT) begin
                  cnt_nxt = '0;
                  if (last_r || !f_valid) begin
                     state_nxt = HBF_S_FCS;
                  end else begin
                     sh_nxt = f_word[7:0];
                     last_nxt = f_word[8];
                     f_pop = 1'b1;
                  end
               end
            end
         end
         HBF_S_FCS: begin
            if (stuff) begin
               b = 1'b0;
               ones_nxt = '0;
            end else begin
               b = ~crc_r[cnt_r];
               ones_nxt = b ? 3'(ones_r + 1'b1) : 3'h0;
               cnt_nxt = 4'(cnt_r + 1'b1);
               if (cnt_r == `HBF_LAST_FCS) begin
                  state_nxt = HBF_S_CLOSE;
                  cnt_nxt = '0;
               end
            end
         end
         HBF_S_CLOSE: begin
            if (stuff) begin
               b = 1'b0;
               ones_nxt = '0;
            end else begin
               b = FLAG[cnt_r[2:0]];
               cnt_nxt = 4'(cnt_r + 1'b1);
               if (cnt_r == `HBF_LAST_BIT) begin
                  state_nxt = HBF_S_IDLE;
                  cnt_nxt = '0;
               end
            end
         end
         default: begin
            state_nxt = HBF_S_IDLE;
            cnt_nxt = '0;
         end
      endcase
   end

   // sequencing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= HBF_S_IDLE;
         cnt_r <= '0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // datapath
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ones_r <= '0;
         sh_r <= '0;
         last_r <= 1'b0;
         crc_r <= `HBF_CRC_INIT;
      end else if (clk_en) begin
         ones_r <= ones_nxt;
         sh_r <= sh_nxt;
         last_r <= last_nxt;
         crc_r <= crc_nxt;
      end
   end

   // idle fill taken at 8-bit boundaries, no partial flag on the line
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fill_r <= 1'b0;
      end else if (clk_en && ((state_r != HBF_S_IDLE) ||
                              (cnt_r[2:0] == 3'h7))) begin
         fill_r <= idle_flags;
      end
   end

   // line driver
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_r <= 1'b1;
      end else if (clk_en) begin
         bit_r <= b;
      end
   end

   assign link.line_bit = bit_r;
endmodule
`default_nettype wire

// ---- shared/hbf_if.sv ----
// serial line between transmitting and receiving station
// assumes both ends share clk and clk_en; one bit per enabled cycle
`timescale 1ns/10ps
`default_nettype none
interface hbf_if;
   logic line_bit;
   modport tx_end(output line_bit);
   modport rx_end(input line_bit);
endinterface
`default_nettype wire

// ---- shared/hbf_map.svh ----
// constants of the bit framer: flag, check sequence, stuffing
// assumes inclusion by bare name from package and bench files
`ifndef HBF_MAP_SVH
`define HBF_MAP_SVH
`define HBF_FLAG 8'h7E
`define HBF_CRC_POLY 16'h8408
`define HBF_CRC_INIT 16'hFFFF
`define HBF_CRC_GOOD 16'hF0B8
`define HBF_STUFF_RUN 3'h5
`define HBF_FLAG_RUN 3'h6
`define HBF_LAST_BIT 4'h7
`define HBF_LAST_FCS 4'hF
`define HBF_MIN_BYTES 4'h2
`endif

// ---- shared/hbf_pkg.sv ----
// types and crc helpers shared by both ends of the bit framer
// assumes hbf_map.svh on the include path
`include "hbf_map.svh"
package hbf_pkg;
   typedef logic [7:0] hbf_byte_t;
   typedef logic [15:0] hbf_crc_t;
   typedef enum logic [2:0] {
      HBF_S_IDLE = 3'b000,
      HBF_S_OPEN = 3'b001,
      HBF_S_DATA = 3'b010,
      HBF_S_FCS = 3'b011,
      HBF_S_CLOSE = 3'b100
   } hbf_tx_state_e;

   // one bit, lsb first, reflected polynomial
   function automatic hbf_crc_t hbf_crc_step(hbf_crc_t crc, logic b);
      logic fb;
      hbf_crc_t c;
      fb = crc[0] ^ b;
      c = {1'b0, crc[15:1]};
      if (fb) begin
         c = c ^ `HBF_CRC_POLY;
      end
      return c;
   endfunction

   function automatic hbf_crc_t hbf_crc_byte(hbf_crc_t crc, hbf_byte_t d);
      hbf_crc_t c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         c = hbf_crc_step(c, d[i]);
      end
      return c;
   endfunction
endpackage
